// file: hw/ebt_pkg.sv
/*
  constants for the eight-bit waveform timer: register map, field positions,
  mode and action codes, reset values and period figures.
  assumes a 32-bit classic wishbone bus and a tick enable on the same clock.
*/
package ebt_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10;

  // control fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ACT_LSB = 2;
  localparam int unsigned CTRL_DIR_BIT = 4;
  localparam int unsigned CTRL_PORT_BIT = 5;
  // status fields, write one to clear
  localparam int unsigned STAT_OVF_BIT = 0;
  localparam int unsigned STAT_MATCH_BIT = 1;
  // state fields
  localparam int unsigned STATE_ACT_LSB = 0;
  localparam int unsigned STATE_DOWN_BIT = 8;
  localparam int unsigned STATE_WAVE_BIT = 9;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;
  localparam logic [CNT_W-1:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  localparam int unsigned FAST_PERIOD_TICKS = 256;
  localparam int unsigned PHASE_PERIOD_TICKS = 510;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } ebt_dir_t;
endpackage

// file: hw/ebt_timer.sv
/*
  eight-bit timer with one compare channel: normal, clear-on-match, fast pwm
  and phase-correct pwm counting, overflow and match flags, waveform output
  and pin override, all reached over a classic wishbone slave.
  assumes timer_tick is a one-cycle enable made on ref_clk by a prescaler.
*/
`timescale 1ns/10ps
module ebt_timer (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ebt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ebt_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ebt_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wave_pin_out,
  output logic wave_pin_oe,
  output logic overflow_flag,
  output logic match_flag
);
  import ebt_pkg::*;

  logic ack_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] wave_mode_sel_reg;
  logic [1:0] output_action_sel_reg;
  logic dir_bit_reg;
  logic port_bit_reg;
  logic [CNT_W-1:0] count_value_reg;
  logic [CNT_W-1:0] count_value_next;
  logic [CNT_W-1:0] compare_buf_reg;
  logic [CNT_W-1:0] compare_value_reg;
  logic [CNT_W-1:0] compare_value_next;
  ebt_dir_t dir_reg;
  ebt_dir_t dir_next;
  logic wave_out_reg;
  logic wave_out_next;
  logic block_reg;
  logic ovf_reg;
  logic match_reg;
  logic pin_out_reg;
  logic pin_oe_reg;

  // bus decode; a write commits on the edge where ack is seen high
  wire req = wb_cyc_i & wb_stb_i;
  wire commit = req & ack_reg & wb_we_i & wb_sel_i[0];
  wire sel_ctrl = (wb_adr_i == OFS_CTRL);
  wire sel_count = (wb_adr_i == OFS_COUNT);
  wire sel_compare = (wb_adr_i == OFS_COMPARE);
  wire sel_status = (wb_adr_i == OFS_STATUS);
  wire sel_state = (wb_adr_i == OFS_STATE);
  wire wr_ctrl = commit & sel_ctrl;
  wire wr_count = commit & sel_count;
  wire wr_compare = commit & sel_compare;
  wire wr_status = commit & sel_status;
  wire [CNT_W-1:0] wbyte = wb_dat_i[CNT_W-1:0];

  // mode decode
  wire is_normal = (wave_mode_sel_reg == MODE_NORMAL);
  wire is_phase = (wave_mode_sel_reg == MODE_PHASE);
  wire is_clear = (wave_mode_sel_reg == MODE_CLEAR);
  wire is_fast = (wave_mode_sel_reg == MODE_FAST);
  wire is_pwm = is_phase | is_fast;
  wire at_max = (count_value_reg == CNT_MAX);
  wire at_bottom = (count_value_reg == CNT_BOTTOM);
  wire going_up = (dir_reg == DIR_UP);
  // a counter write hides the match on the following tick
  wire match_hit = (count_value_reg == compare_value_reg) & ~block_reg;
  wire tick_match = timer_tick & match_hit;
  wire tick_wrap = timer_tick & at_max & ~is_phase;
  wire phase_top = timer_tick & is_phase & going_up & at_max;
  wire phase_bottom = timer_tick & is_phase & ~going_up & (count_value_reg == CNT_BOTTOM + 8'h01);
  wire ovf_set = (~is_phase & tick_wrap) | phase_bottom;
  // pwm buffer copies at the counting extreme
  wire buf_load = (is_fast & tick_wrap) | phase_top;
  wire ocr_is_max = (compare_value_reg == CNT_MAX);
  wire ocr_is_min = (compare_value_reg == CNT_BOTTOM);
  wire act_set = (output_action_sel_reg == ACT_SET);
  wire act_none = (output_action_sel_reg == ACT_NONE);

  // counter sequence; software write wins over count and clear
  always_comb begin
    count_value_next = count_value_reg;
    dir_next = dir_reg;
    if (wr_count) begin
      count_value_next = wbyte;
    end else if (timer_tick) begin
      unique case (wave_mode_sel_reg)
        MODE_NORMAL: begin
          count_value_next = count_value_reg + 8'h01;
        end
        MODE_CLEAR: begin
          if (match_hit) begin
            count_value_next = CNT_BOTTOM;
          end else begin
            count_value_next = count_value_reg + 8'h01;
          end
        end
        MODE_FAST: begin
          count_value_next = at_max ? CNT_BOTTOM : count_value_reg + 8'h01;
        end
        MODE_PHASE: begin
          // max and bottom each last exactly one tick, 510 ticks a period
          if (going_up) begin
            if (at_max) begin
              dir_next = DIR_DOWN;
              count_value_next = count_value_reg - 8'h01;
            end else begin
              count_value_next = count_value_reg + 8'h01;
            end
          end else begin
            if (at_bottom) begin
              dir_next = DIR_UP;
              count_value_next = count_value_reg + 8'h01;
            end else begin
              count_value_next = count_value_reg - 8'h01;
            end
          end
        end
      endcase
    end
  end

  // active compare: direct in non-pwm modes, buffered in pwm modes
  always_comb begin
    compare_value_next = compare_value_reg;
    if (wr_compare & ~is_pwm) begin
      compare_value_next = wbyte;
    end else if (buf_load) begin
      compare_value_next = compare_buf_reg;
    end
  end

  // waveform state; action 0 never touches it
  always_comb begin
    wave_out_next = wave_out_reg;
    if (timer_tick & ~act_none) begin
      unique case (wave_mode_sel_reg)
        MODE_NORMAL, MODE_CLEAR: begin
          if (match_hit) begin
            unique case (output_action_sel_reg)
              ACT_TOGGLE: wave_out_next = ~wave_out_reg;
              ACT_CLEAR: wave_out_next = 1'b0;
              ACT_SET: wave_out_next = 1'b1;
              default: wave_out_next = wave_out_reg;
            endcase
          end
        end
        MODE_FAST: begin
          if (output_action_sel_reg == ACT_TOGGLE) begin
            if (match_hit) begin
              wave_out_next = ~wave_out_reg;
            end
          end else if (at_max) begin
            // wrap level wins, so compare at max holds a constant level
            wave_out_next = ~act_set;
          end else if (match_hit) begin
            wave_out_next = act_set;
          end
        end
        MODE_PHASE: begin
          // toggle has no meaning on a dual slope and is ignored
          if (output_action_sel_reg != ACT_TOGGLE) begin
            if (going_up & at_max) begin
              wave_out_next = ocr_is_max ? ~act_set : act_set;
            end else if (match_hit) begin
              if (going_up | ocr_is_min) begin
                wave_out_next = act_set;
              end else begin
                wave_out_next = ~act_set;
              end
            end
          end
        end
      endcase
    end
  end

  // read mux, held in a flop with ack
  wire [DATA_W-1:0] ctrl_rd = {26'h000_0000, port_bit_reg, dir_bit_reg, output_action_sel_reg, wave_mode_sel_reg};
  wire [DATA_W-1:0] stat_rd = {30'h0000_0000, match_reg, ovf_reg};
  wire [DATA_W-1:0] state_rd = {22'h00_0000, wave_out_reg, ~going_up, compare_value_reg};
  wire [DATA_W-1:0] rd_mux = sel_ctrl ? ctrl_rd :
                             sel_count ? {24'h00_0000, count_value_reg} :
                             sel_compare ? {24'h00_0000, compare_buf_reg} :
                             sel_status ? stat_rd :
                             sel_state ? state_rd : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wave_mode_sel_reg <= RST_CTRL[CTRL_MODE_LSB +: 2];
      output_action_sel_reg <= RST_CTRL[CTRL_ACT_LSB +: 2];
      dir_bit_reg <= RST_CTRL[CTRL_DIR_BIT];
      port_bit_reg <= RST_CTRL[CTRL_PORT_BIT];
    end else if (wr_ctrl) begin
      wave_mode_sel_reg <= wbyte[CTRL_MODE_LSB +: 2];
      output_action_sel_reg <= wbyte[CTRL_ACT_LSB +: 2];
      dir_bit_reg <= wbyte[CTRL_DIR_BIT];
      port_bit_reg <= wbyte[CTRL_PORT_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_value_reg <= RST_COUNT;
      dir_reg <= DIR_UP;
      compare_buf_reg <= RST_COMPARE;
      compare_value_reg <= RST_COMPARE;
      wave_out_reg <= 1'b0;
      block_reg <= 1'b0;
    end else begin
      count_value_reg <= count_value_next;
      dir_reg <= dir_next;
      compare_value_reg <= compare_value_next;
      wave_out_reg <= wave_out_next;
      if (wr_compare) begin
        compare_buf_reg <= wbyte;
      end
      if (wr_count) begin
        block_reg <= 1'b1;
      end else if (timer_tick) begin
        block_reg <= 1'b0;
      end
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ovf_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_set | (ovf_reg & ~(wr_status & wbyte[STAT_OVF_BIT]));
      match_reg <= tick_match | (match_reg & ~(wr_status & wbyte[STAT_MATCH_BIT]));
    end
  end

  // pin: override only while an action is chosen; driver follows direction bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_out_reg <= act_none ? port_bit_reg : wave_out_reg;
      pin_oe_reg <= dir_bit_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign wave_pin_out = pin_out_reg;
  assign wave_pin_oe = pin_oe_reg;
  assign overflow_flag = ovf_reg;
  assign match_flag = match_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_NORMAL_WRAP: assert property (
    timer_tick & is_normal & at_max & ~wr_count & ~wr_ctrl |=> count_value_reg == CNT_BOTTOM)
    else $error("normal mode did not roll over to zero");
  AST_NORMAL_OVF: assert property (
    timer_tick & is_normal & at_max & ~wr_count & ~wr_ctrl |=> ovf_reg && count_value_reg == CNT_BOTTOM)
    else $error("overflow not raised as counter became zero");
  AST_COUNT_WRITE: assert property (
    wr_count |=> count_value_reg == $past(wbyte))
    else $error("counter write not taken");
  AST_CLEAR_AT_MATCH: assert property (
    timer_tick & is_clear & match_hit & ~wr_count & ~wr_ctrl |=> count_value_reg == CNT_BOTTOM)
    else $error("clear-on-match mode did not clear on match");
  AST_CLEAR_DIRECT: assert property (
    wr_compare & is_clear |=> compare_value_reg == $past(wbyte))
    else $error("compare write not immediate in clear-on-match mode");
  AST_CLEAR_TOGGLE: assert property (
    timer_tick & is_clear & match_hit & output_action_sel_reg == ACT_TOGGLE & ~wr_ctrl
    |=> wave_out_reg != $past(wave_out_reg))
    else $error("output did not toggle on match");
  AST_CLEAR_OVF: assert property (
    timer_tick & is_clear & at_max & ~wr_ctrl |=> ovf_reg)
    else $error("overflow missing on max to zero step");
  AST_FAST_WRAP: assert property (
    timer_tick & is_fast & at_max & ~wr_count & ~wr_ctrl |=> count_value_reg == CNT_BOTTOM)
    else $error("fast pwm did not wrap after max");
  AST_FAST_SET_AT_WRAP: assert property (
    timer_tick & is_fast & at_max & output_action_sel_reg == ACT_CLEAR & ~wr_ctrl |=> wave_out_reg)
    else $error("non-inverted fast pwm not set at wrap");
  AST_PHASE_TOP: assert property (
    timer_tick & is_phase & going_up & at_max & ~wr_count & ~wr_ctrl
    |=> count_value_reg == CNT_MAX - 8'h01 && dir_reg == DIR_DOWN)
    else $error("phase-correct did not turn at max");
  AST_PHASE_OVF: assert property (
    phase_bottom & ~wr_ctrl & ~wr_count |=> ovf_reg && count_value_reg == CNT_BOTTOM)
    else $error("phase-correct overflow not at bottom");
  AST_BUF_HOLD: assert property (
    is_pwm & ~buf_load & ~wr_ctrl |=> $stable(compare_value_reg))
    else $error("active compare changed away from the extreme");
  AST_NO_TICK: assert property (
    ~timer_tick & ~wr_count & ~wr_ctrl |=> $stable(count_value_reg) && $stable(wave_out_reg))
    else $error("counter or output moved without a tick");
  AST_PIN_DIR: assert property (
    wr_ctrl |=> ##1 wave_pin_oe == $past(wbyte[CTRL_DIR_BIT], 2))
    else $error("pin enable does not follow direction bit");

  AST_NORMAL_STEP: assert property (
    timer_tick & is_normal & ~wr_count & ~wr_ctrl
    |=> count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("normal mode did not step up by one");
  AST_CLEAR_RUN_ON: assert property (
    timer_tick & is_clear & ~match_hit & ~wr_count & ~wr_ctrl
    |=> count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("clear-on-match mode did not count past a missed match");
  AST_FAST_STEP: assert property (
    timer_tick & is_fast & ~at_max & ~wr_count & ~wr_ctrl
    |=> count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("fast pwm did not step up by one");
  AST_PHASE_BOTTOM: assert property (
    timer_tick & is_phase & ~going_up & at_bottom & ~wr_count & ~wr_ctrl
    |=> count_value_reg == CNT_BOTTOM + 8'h01 && dir_reg == DIR_UP)
    else $error("phase-correct did not turn at bottom");
  AST_OVF_HELD: assert property (
    ovf_reg & ~(wr_status & wbyte[STAT_OVF_BIT]) |=> ovf_reg)
    else $error("overflow flag cleared by hardware");
  AST_FAST_OVF: assert property (
    timer_tick & is_fast & at_max & ~wr_ctrl |=> ovf_reg)
    else $error("fast pwm overflow missing at max");
  AST_MATCH_SET: assert property (
    timer_tick & count_value_reg == compare_value_reg & ~block_reg |=> match_reg)
    else $error("match flag not set after equality");
  AST_MATCH_BLOCKED: assert property (
    timer_tick & block_reg & ~match_reg & ~wr_status |=> !match_reg)
    else $error("match flag set on the tick after a counter write");
  AST_FAST_CLEAR_MATCH: assert property (
    timer_tick & is_fast & match_hit & ~at_max & output_action_sel_reg[1] & ~wr_ctrl
    |=> wave_out_reg == $past(act_set))
    else $error("fast pwm output wrong after match");
  AST_FAST_WRAP_LEVEL: assert property (
    timer_tick & is_fast & at_max & output_action_sel_reg[1] & ~wr_ctrl |=> wave_out_reg != $past(act_set))
    else $error("fast pwm output wrong at wrap");
  AST_FAST_TOGGLE: assert property (
    timer_tick & is_fast & match_hit & output_action_sel_reg == ACT_TOGGLE & ~wr_ctrl
    |=> wave_out_reg != $past(wave_out_reg))
    else $error("fast pwm toggle missing on match");
  AST_PHASE_UP_MATCH: assert property (
    timer_tick & is_phase & going_up & ~at_max & match_hit & output_action_sel_reg[1] & ~wr_ctrl
    |=> wave_out_reg == $past(act_set))
    else $error("phase-correct output wrong after up-counting match");
  AST_PHASE_DOWN_MATCH: assert property (
    timer_tick & is_phase & ~going_up & match_hit & ~ocr_is_min & output_action_sel_reg[1] & ~wr_ctrl
    |=> wave_out_reg != $past(act_set))
    else $error("phase-correct output wrong after down-counting match");
  AST_PHASE_TOP_LEVEL: assert property (
    timer_tick & is_phase & going_up & at_max & ~ocr_is_max & output_action_sel_reg[1] & ~wr_ctrl
    |=> wave_out_reg == $past(act_set))
    else $error("phase-correct output at max not at up-counting level");
  AST_PHASE_MAX_HOLD: assert property (
    timer_tick & is_phase & going_up & at_max & ocr_is_max & output_action_sel_reg[1] & ~wr_ctrl
    |=> wave_out_reg != $past(act_set))
    else $error("phase-correct compare at max does not hold its level");
  AST_ACT_NONE_HOLD: assert property (
    act_none & ~wr_ctrl |=> $stable(wave_out_reg))
    else $error("output state moved with no action chosen");
  AST_PIN_PORT: assert property (
    act_none |=> wave_pin_out == $past(port_bit_reg))
    else $error("pin left its port function with no action chosen");

  COV_FAST_PWM: cover property (tick_wrap & is_fast & output_action_sel_reg == ACT_CLEAR);
  COV_PHASE_TURN: cover property (phase_top ##[1:600] phase_bottom);
  COV_CLEAR_TOGGLE: cover property (tick_match & is_clear & output_action_sel_reg == ACT_TOGGLE);
  COV_SET_BEATS_CLEAR: cover property (ovf_set & wr_status & wbyte[STAT_OVF_BIT]);
endmodule

// file: verification/test_eight_bit_timer_waveform_modes.sv
/*
  self-checking bench for the eight-bit waveform timer: wishbone register
  access, counting sequences, flags and waveform duty in fast, phase-correct and clear-on-match modes.
  assumes ebt_pkg and ebt_timer are compiled first; the bench drives all ports.
*/
`timescale 1ns/10ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_eight_bit_timer_waveform_modes;
  import ebt_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic timer_tick = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [DATA_W-1:0] dat = 32'h0000_0000;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o, wave_pin_out, wave_pin_oe, overflow_flag, match_flag;
  int num_errors = 0;
  int check_count = 0;

  ebt_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .timer_tick(timer_tick), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wave_pin_out(wave_pin_out), .wave_pin_oe(wave_pin_oe),
    .overflow_flag(overflow_flag), .match_flag(match_flag));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task end_of_test;
    $display("comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high, only the watchdog ends a wait
  task wb_cycle(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wb_cycle(1'b1, a, {24'h00_0000, d});
  endtask

  task rdr(input logic [ADDR_W-1:0] a);
    wb_cycle(1'b0, a, 32'h0000_0000);
  endtask

  // exactly n enabled edges, then settle past the last one
  task tick_n(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      timer_tick <= 1'b1;
    end
    @(posedge ref_clk);
    timer_tick <= 1'b0;
    #1;
  endtask

  // free-running tick, count high cycles of the pin over one window
  task duty(input logic [7:0] ctrl, input logic [7:0] cmp, input int win, input int exp);
    int hi;
    hi = 0;
    wr(OFS_CTRL, ctrl);
    wr(OFS_COMPARE, cmp);
    @(posedge ref_clk);
    timer_tick <= 1'b1;
    // a buffered compare can need two extremes before the level settles
    repeat (1100) @(posedge ref_clk);
    repeat (win) begin
      @(posedge ref_clk);
      hi += (wave_pin_out === 1'b1);
    end
    timer_tick <= 1'b0;
    `CHECK(hi, exp)
  endtask

  task t_reset;
    rdr(OFS_CTRL);
    `CHECK(rd, 32'h0000_0000)
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_0000)
    rdr(8'h20);
    `CHECK(rd, 32'h0000_0000)
    `CHECK({overflow_flag, match_flag, wave_pin_oe}, 3'h0)
    $display("test reset done");
  endtask

  task t_normal;
    wr(OFS_CTRL, 8'h10);
    wr(OFS_COUNT, 8'hFE);
    tick_n(1);
    `CHECK(overflow_flag, 1'b0)
    `CHECK(wave_pin_oe, 1'b1)
    tick_n(1);
    `CHECK(overflow_flag, 1'b1)
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_0000)
    repeat (5) @(posedge ref_clk);
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_0000)
    wr(OFS_COUNT, 8'h80);
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_0080)
    wr(OFS_STATUS, 8'h03);
    #1;
    `CHECK(overflow_flag, 1'b0)
    wr(OFS_CTRL, 8'h00);
    #1;
    @(posedge ref_clk);
    #1;
    `CHECK(wave_pin_oe, 1'b0)
    $display("test normal done");
  endtask

  task t_clear;
    wr(OFS_COMPARE, 8'h03);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h16);
    tick_n(3);
    `CHECK(match_flag, 1'b0)
    tick_n(1);
    `CHECK(match_flag, 1'b1)
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_0000)
    rdr(OFS_STATE);
    `CHECK(rd[9], 1'b1)
    wr(OFS_COUNT, 8'h05);
    wr(OFS_COMPARE, 8'h02);
    wr(OFS_STATUS, 8'h03);
    tick_n(250);
    `CHECK(overflow_flag, 1'b0)
    tick_n(1);
    `CHECK(overflow_flag, 1'b1)
    tick_n(3);
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_0000)
    $display("test clear-on-match done");
  endtask

  task t_fast;
    wr(OFS_STATUS, 8'h03);
    wr(OFS_CTRL, 8'h1B);
    wr(OFS_COMPARE, 8'h40);
    rdr(OFS_STATE);
    `CHECK(rd[7:0], 8'h02)
    wr(OFS_COUNT, 8'hFF);
    tick_n(1);
    `CHECK(overflow_flag, 1'b1)
    rdr(OFS_STATE);
    `CHECK(rd, 32'h0000_0240)
    tick_n(64);
    `CHECK(match_flag, 1'b0)
    tick_n(1);
    `CHECK(match_flag, 1'b1)
    rdr(OFS_STATE);
    `CHECK(rd, 32'h0000_0040)
    $display("test fast pwm done");
  endtask

  task t_phase;
    wr(OFS_STATUS, 8'h03);
    wr(OFS_CTRL, 8'h19);
    wr(OFS_COUNT, 8'hFD);
    tick_n(2);
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_00FF)
    tick_n(1);
    rdr(OFS_STATE);
    `CHECK(rd[8], 1'b1)
    rdr(OFS_COUNT);
    `CHECK(rd, 32'h0000_00FE)
    wr(OFS_COUNT, 8'h02);
    tick_n(1);
    `CHECK(overflow_flag, 1'b0)
    tick_n(1);
    `CHECK(overflow_flag, 1'b1)
    $display("test phase pwm done");
  endtask

  task t_duty;
    duty(8'h1B, 8'h40, 256, 65);
    duty(8'h1F, 8'h40, 256, 191);
    duty(8'h1B, 8'h00, 256, 1);
    duty(8'h1B, 8'hFF, 256, 256);
    duty(8'h1F, 8'hFF, 256, 0);
    duty(8'h17, 8'h40, 512, 256);
    duty(8'h16, 8'h03, 8, 4);
    duty(8'h19, 8'h40, 510, 128);
    duty(8'h1D, 8'h40, 510, 382);
    duty(8'h19, 8'h00, 510, 0);
    duty(8'h19, 8'hFF, 510, 510);
    duty(8'h1D, 8'h00, 510, 510);
    duty(8'h33, 8'h40, 256, 256);
    $display("test duty table done");
  endtask

  // whole run is about 19000 cycles; limit leaves ample margin
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_normal();
    t_clear();
    t_fast();
    t_phase();
    t_duty();
    end_of_test();
  end
endmodule
